// [bench/tsbm_host_model.sv]
// host side model: register accesses, conversion start and status clear
`timescale 1ns/1ps
module tsbm_host_model (
   // clock
   input wire logic clk_i,
   // register port
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   // converter start and status clear
   output logic conv_start_o,
   output logic irq_clr_o
);
   // idle levels at time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
      conv_start_o = 1'b0;
      irq_clr_o = 1'b0;
   end
   // one-cycle write, data inverted once released
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~d;
   endtask
   // read data stands one cycle after the address
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      repeat (2) @(posedge clk_i);
      #1;
      d = reg_rdata_i;
   endtask
   // start pulse after select and range are set
   task automatic start_conv();
      @(posedge clk_i);
      conv_start_o <= 1'b1;
      @(posedge clk_i);
      conv_start_o <= 1'b0;
   endtask
   // reading in half units of the range: code times step plus range floor
   function automatic int temp_half(input logic [7:0] code, input logic [1:0] rng);
      int step;
      int base;
      step = rng[0] ? 2 : 1;
      base = (rng == 2'h2) ? 0 : ((rng == 2'h3) ? -80 : -128);
      return step * int'(code) + base;
   endfunction
   // one-cycle clear pulse drops the pending event
   task automatic clear_irq();
      @(posedge clk_i);
      irq_clr_o <= 1'b1;
      @(posedge clk_i);
      irq_clr_o <= 1'b0;
   endtask
endmodule

// [bench/tsbm_props.sv]
// concurrent checks on the ports of the sensor and battery monitor block
`timescale 1ns/1ps
module tsbm_props #(
   parameter int CONV_CYCLES = 20,
   parameter int WINDOW_CYCLES = 10
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // converter side
   input wire logic [2:0] conv_sel_i,
   input wire logic testbus_temp_i,
   input wire logic conv_start_i,
   input wire logic conv_busy_o,
   input wire logic temp_sensor_on_o,
   input wire logic [7:0] temp_value_o,
   // battery monitor and interrupt
   input wire logic battery_monitor_en_i,
   input wire logic sleep_i,
   input wire logic battery_meas_on_o,
   input wire logic rc_osc_keep_o,
   input wire logic battery_irq_en_i,
   input wire logic battery_irq_clr_i,
   input wire logic battery_irq_pend_o,
   input wire logic interrupt_out_low_o
);
   int busy_cnt;
   int win_cnt;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // cycles spent in the current conversion
   always_ff @(posedge clk_i) begin
      busy_cnt <= (rst_i || !conv_busy_o) ? 0 : busy_cnt + 1;
   end
   // cycles spent in the current measurement window
   always_ff @(posedge clk_i) begin
      win_cnt <= (rst_i || !battery_meas_on_o) ? 0 : win_cnt + 1;
   end
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   AST_SENSOR_ON: assert property (
      !$past(rst_i) |-> temp_sensor_on_o == ($past(conv_sel_i) == 3'h0 || $past(testbus_temp_i)))
      else $error("sensor power does not follow select or test bus");
   AST_START_TAKEN: assert property (conv_start_i && !conv_busy_o |=> conv_busy_o)
      else $error("idle start not taken");
   AST_BUSY_LEN: assert property (
      !$past(rst_i) && $fell(conv_busy_o) |-> busy_cnt == CONV_CYCLES)
      else $error("conversion length wrong");
   AST_VALUE_HOLD: assert property (
      !$past(rst_i) && !$fell(conv_busy_o) |-> $stable(temp_value_o))
      else $error("result changed outside conversion end");
   AST_MEAS_OFF: assert property (!battery_monitor_en_i |=> !battery_meas_on_o)
      else $error("measurement while monitor disabled");
   AST_MEAS_LEN: assert property (
      !$past(rst_i) && $fell(battery_meas_on_o) && $past(battery_monitor_en_i)
      |-> win_cnt == WINDOW_CYCLES)
      else $error("measurement window length wrong");
   AST_RC_KEEP: assert property (
      !$past(rst_i) |-> rc_osc_keep_o == ($past(battery_monitor_en_i) && $past(sleep_i)))
      else $error("oscillator keep does not follow enable and sleep");
   AST_PEND_STICKY: assert property (
      battery_irq_pend_o && !battery_irq_clr_i |=> battery_irq_pend_o)
      else $error("pending event lost without clear");
   AST_IRQ_MASKED: assert property (!battery_irq_en_i |=> interrupt_out_low_o)
      else $error("interrupt driven while disabled");
   AST_IRQ_DRIVE: assert property (
      battery_irq_pend_o && battery_irq_en_i && !battery_irq_clr_i |=> !interrupt_out_low_o)
      else $error("enabled pending event not driven");
   // main scenarios
   COV_CONV: cover property ($fell(conv_busy_o));
   COV_PEND: cover property ($rose(battery_irq_pend_o));
   COV_IRQ: cover property ($fell(interrupt_out_low_o));
endmodule

// [bench/tsbm_tb_top.sv]
// self-checking bench for the temperature sensor and battery monitor block
`timescale 1ns/1ps
module tsbm_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, temp_value_o, rd;
   logic [7:0] byte_converter_i = 8'h00;
   logic reg_wr_i, conv_start_i, conv_busy_o, temp_sensor_on_o, abs_temp_mode_o, trim_en_o;
   logic [2:0] conv_sel_i = 3'h1;
   logic testbus_temp_i = 1'b0;
   logic [1:0] temp_range_o, trim_code_o, vbg_trim_o;
   logic battery_monitor_en_i = 1'b0;
   logic sleep_i = 1'b0;
   logic lf_clk_i = 1'b0;
   logic battery_irq_en_i = 1'b0;
   logic [4:0] battery_code_i = 5'h13;
   logic battery_irq_clr_i, battery_meas_on_o, rc_osc_keep_o, battery_irq_pend_o;
   logic interrupt_out_low_o;
   int err_total = 0;
   int checks_done = 0;
   // register table and conversion cases
   logic [7:0] r_adr [5] = '{8'h12, 8'h13, 8'h1A, 8'h1B, 8'h55};
   logic [7:0] r_rst [5] = '{8'h20, 8'h00, 8'h14, 8'h00, 8'h00};
   logic [7:0] c_ctl [4] = '{8'h20, 8'h60, 8'h80, 8'hFD};
   logic [7:0] c_off [4] = '{8'h05, 8'h20, 8'h20, 8'h01};
   logic [7:0] c_raw [4] = '{8'h10, 8'hF0, 8'h33, 8'hFE};
   logic [7:0] c_exp [4] = '{8'h15, 8'hFF, 8'h33, 8'hFF};
   // design, host model and clocks
   tsbm_top #(.CONV_CYCLES(20), .WINDOW_CYCLES(10), .INTERVAL_TICKS(4)) dut (
      .clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .conv_sel_i,
      .testbus_temp_i, .conv_start_i, .conv_busy_o, .byte_converter_i, .temp_sensor_on_o,
      .temp_range_o, .abs_temp_mode_o, .trim_en_o, .trim_code_o, .vbg_trim_o, .temp_value_o,
      .battery_monitor_en_i, .sleep_i, .lf_clk_i, .battery_code_i, .battery_meas_on_o,
      .rc_osc_keep_o, .battery_irq_en_i, .battery_irq_clr_i, .battery_irq_pend_o,
      .interrupt_out_low_o);
   tsbm_host_model host (.clk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o), .conv_start_o(conv_start_i),
      .irq_clr_o(battery_irq_clr_i));
   always #20 clk_i = ~clk_i;
   always #733 lf_clk_i = ~lf_clk_i;
   // ------------------------------------------------------------
   // compare, wait and closing tasks
   // ------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected bit at %0t: got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic wait_level(ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (s !== v) begin
         err_total++;
         $display("unexpected wait at %0t: level never reached", $time);
      end
   endtask
   task automatic wait_sample();
      wait_level(battery_meas_on_o, 1'b1, 400);
      wait_level(battery_meas_on_o, 1'b0, 40);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      $display("unexpected hang at %0t: run did not finish", $time);
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (r_adr[i]) begin
         host.reg_read(r_adr[i], rd);
         chk_byte(rd, r_rst[i]);
      end
      host.reg_write(8'h1A, 8'hFF);
      host.reg_read(8'h1A, rd);
      chk_byte(rd, 8'h1F);
      host.reg_write(8'h1B, 8'h1F);
      host.reg_read(8'h1B, rd);
      chk_byte(rd, 8'h00);
      host.reg_read(8'h12, rd);
      chk_bit(temp_sensor_on_o, 1'b0);
      @(posedge clk_i);
      conv_sel_i <= 3'h2;
      testbus_temp_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      chk_bit(temp_sensor_on_o, 1'b1);
      @(posedge clk_i);
      conv_sel_i <= 3'h0;
      testbus_temp_i <= 1'b0;
      foreach (c_ctl[i]) begin
         host.reg_write(8'h12, c_ctl[i]);
         host.reg_write(8'h13, c_off[i]);
         @(posedge clk_i);
         byte_converter_i <= c_raw[i];
         host.start_conv();
         host.start_conv();
         wait_level(conv_busy_o, 1'b0, 60);
         chk_byte(temp_value_o, c_exp[i]);
         chk_byte({temp_range_o, abs_temp_mode_o, trim_en_o, trim_code_o, vbg_trim_o},
            {c_ctl[i][7:6], c_ctl[i][7:5] == 3'b100, c_ctl[i][4:0]});
      end
      chk_bit(temp_sensor_on_o, 1'b1);
      chk_bit(host.temp_half(temp_value_o, temp_range_o) == 430, 1'b1);
      host.reg_write(8'h1A, 8'h14);
      @(posedge clk_i);
      battery_monitor_en_i <= 1'b1;
      repeat (3) wait_sample();
      @(posedge clk_i);
      battery_code_i <= 5'h14;
      wait_sample();
      @(posedge clk_i);
      battery_code_i <= 5'h13;
      repeat (3) wait_sample();
      chk_bit(battery_irq_pend_o, 1'b0);
      wait_sample();
      repeat (3) @(posedge clk_i);
      #1;
      chk_bit(battery_irq_pend_o, 1'b1);
      chk_bit(interrupt_out_low_o, 1'b1);
      host.reg_read(8'h1B, rd);
      chk_byte(rd, 8'h13);
      @(posedge clk_i);
      battery_irq_en_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk_bit(interrupt_out_low_o, 1'b0);
      host.clear_irq();
      repeat (3) @(posedge clk_i);
      #1;
      chk_bit(battery_irq_pend_o, 1'b0);
      chk_bit(interrupt_out_low_o, 1'b1);
      @(posedge clk_i);
      sleep_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk_bit(rc_osc_keep_o, 1'b1);
      @(posedge clk_i);
      battery_monitor_en_i <= 1'b0;
      battery_code_i <= 5'h02;
      repeat (700) @(posedge clk_i);
      host.reg_read(8'h1B, rd);
      chk_byte(rd, 8'h13);
      chk_bit(battery_irq_pend_o, 1'b0);
      chk_bit(battery_meas_on_o, 1'b0);
      chk_bit(rc_osc_keep_o, 1'b0);
      wrap_up();
   end
endmodule
bind tsbm_top tsbm_props #(.CONV_CYCLES(CONV_CYCLES), .WINDOW_CYCLES(WINDOW_CYCLES)) props (
   .clk_i, .rst_i, .conv_sel_i, .testbus_temp_i, .conv_start_i, .conv_busy_o,
   .temp_sensor_on_o, .temp_value_o, .battery_monitor_en_i, .sleep_i, .battery_meas_on_o,
   .rc_osc_keep_o, .battery_irq_en_i, .battery_irq_clr_i, .battery_irq_pend_o,
   .interrupt_out_low_o);

// [hdl/tsbm_batt_if.sv]
// link between battery sampler timing and the monitor control logic
`timescale 1ns/1ps
interface tsbm_batt_if;
   logic enable;
   logic lf_tick;
   logic meas_on;
   logic sample_stb;

   // timing side
   modport sampler (
      input enable,
      input lf_tick,
      output meas_on,
      output sample_stb
   );

   // control side
   modport ctrl (
      output enable,
      output lf_tick,
      input meas_on,
      input sample_stb
   );
endinterface

// [hdl/tsbm_batt_sampler.sv]
// periodic battery measurement timing: one window per interval of lf ticks
`timescale 1ns/1ps
module tsbm_batt_sampler #(
   parameter int INTERVAL_TICKS = tsbm_pkg::TSBM_INTERVAL_TICKS,
   parameter int WINDOW_CYCLES = tsbm_pkg::TSBM_WINDOW_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link to the control logic
   tsbm_batt_if.sampler bif
);
   import tsbm_pkg::*;

   localparam int IW = $clog2(INTERVAL_TICKS + 1);
   localparam int WW = $clog2(WINDOW_CYCLES + 1);
   localparam logic [IW-1:0] I_LAST = IW'(INTERVAL_TICKS - 1);
   localparam logic [WW-1:0] W_LAST = WW'(WINDOW_CYCLES - 1);

   logic [IW-1:0] tick_cnt_reg;
   logic [WW-1:0] win_cnt_reg;
   logic meas_on_reg;
   logic sample_stb_reg;

   // ---------------------------------------------------------------
   // interval count in low-frequency ticks, restarted after each window
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || !bif.enable || meas_on_reg) begin
         tick_cnt_reg <= '0;
      end else if (bif.lf_tick) begin
         tick_cnt_reg <= (tick_cnt_reg == I_LAST) ? '0 : tick_cnt_reg + IW'(1);
      end
   end

   // measurement window: circuit and converter powered for a fixed time
   always_ff @(posedge clk_i) begin
      if (rst_i || !bif.enable) begin
         meas_on_reg <= 1'b0;
         win_cnt_reg <= '0;
         sample_stb_reg <= 1'b0;
      end else begin
         sample_stb_reg <= 1'b0;
         if (!meas_on_reg) begin
            if (bif.lf_tick && tick_cnt_reg == I_LAST) begin
               meas_on_reg <= 1'b1;
               win_cnt_reg <= '0;
            end
         end else if (win_cnt_reg == W_LAST) begin
            meas_on_reg <= 1'b0;
            sample_stb_reg <= 1'b1;
         end else begin
            win_cnt_reg <= win_cnt_reg + WW'(1);
         end
      end
   end

   assign bif.meas_on = meas_on_reg;
   assign bif.sample_stb = sample_stb_reg;
endmodule

// [hdl/tsbm_pkg.sv]
// shared constants for the temperature sensor and battery monitor block
package tsbm_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] TSBM_ADDR_TEMP_CTRL = 8'h12;
   localparam logic [7:0] TSBM_ADDR_TEMP_OFFS = 8'h13;
   localparam logic [7:0] TSBM_ADDR_BATT_THR = 8'h1A;
   localparam logic [7:0] TSBM_ADDR_BATT_LEVEL = 8'h1B;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] TSBM_RST_TEMP_CTRL = 8'h20;
   localparam logic [7:0] TSBM_RST_TEMP_OFFS = 8'h00;
   localparam logic [4:0] TSBM_RST_BATT_THR = 5'h14;
   localparam logic [4:0] TSBM_RST_BATT_LEVEL = 5'h00;

   // ---------------------------------------------------------------
   // field positions of the temperature sensor control register, and the battery level width
   // ---------------------------------------------------------------
   localparam int TSBM_RANGE_HI = 7;
   localparam int TSBM_RANGE_LO = 6;
   localparam int TSBM_OFFS_EN_BIT = 5;
   localparam int TSBM_TRIM_EN_BIT = 4;
   localparam int TSBM_TRIM_HI = 3;
   localparam int TSBM_TRIM_LO = 2;
   localparam int TSBM_VBG_HI = 1;
   localparam int TSBM_VBG_LO = 0;
   localparam int TSBM_LEVEL_W = 5;

   // range codes and converter select code of the temperature sensor
   localparam logic [1:0] TSBM_RANGE_C_HALF = 2'h0;
   localparam logic [1:0] TSBM_RANGE_C_WIDE = 2'h1;
   localparam logic [1:0] TSBM_RANGE_C_POS = 2'h2;
   localparam logic [1:0] TSBM_RANGE_F_WIDE = 2'h3;
   localparam logic [2:0] TSBM_SEL_TEMP = 3'h0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int TSBM_CLK_PERIOD_NS = 40;
   localparam int TSBM_CONV_TIME_NS = 350000;
   localparam int TSBM_WINDOW_TIME_NS = 250000;
   // least time rounds up
   localparam int TSBM_CONV_CYCLES =
      (TSBM_CONV_TIME_NS + TSBM_CLK_PERIOD_NS - 1) / TSBM_CLK_PERIOD_NS;
   // approximate window rounds down
   localparam int TSBM_WINDOW_CYCLES = TSBM_WINDOW_TIME_NS / TSBM_CLK_PERIOD_NS;
   localparam int TSBM_INTERVAL_TICKS = 32768;
   localparam int TSBM_LOW_READINGS = 4;

endpackage

// [hdl/tsbm_temp_offset.sv]
// digital offset stage: adds the offset to the raw result and saturates
`timescale 1ns/1ps
module tsbm_temp_offset #(
   parameter int DATA_W = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // raw result and offset setting
   input wire logic load_i,
   input wire logic offs_en_i,
   input wire logic [DATA_W-1:0] raw_i,
   input wire logic [DATA_W-1:0] offs_i,
   // corrected result
   output logic [DATA_W-1:0] value_o
);
   import tsbm_pkg::*;

   logic [DATA_W:0] sum;
   logic [DATA_W-1:0] value_reg;

   // one bit wider sum so an overflow is visible
   assign sum = {1'b0, raw_i} + {1'b0, offs_i};

   // ---------------------------------------------------------------
   // result register, loaded at the end of each conversion
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         value_reg <= '0;
      end else if (load_i) begin
         if (!offs_en_i) begin
            value_reg <= raw_i;
         end else if (sum[DATA_W]) begin
            value_reg <= '1;
         end else begin
            value_reg <= sum[DATA_W-1:0];
         end
      end
   end

   assign value_o = value_reg;
endmodule

// [hdl/tsbm_top.sv]
// temperature sensor control and battery monitor, register side and timing
`timescale 1ns/1ps
//
// Contract
// - sensor powered when selected or on test bus
// - range field picks temperature scale
// - offset off with range 10: absolute
// - offset enabled adds offset to result
// - trim enable applies trim to sensor
// - monitor works only while enabled
// - battery digitized to five-bit code
// - level register shows latest code, upper zero
// - measure once per second for window
// - keep RC oscillator running in sleep
// - low when code below threshold
// - four consecutive low readings raise interrupt
// - interrupt output only when enable set
// - start bit busy until conversion ends
module tsbm_top #(
   parameter int CONV_CYCLES = tsbm_pkg::TSBM_CONV_CYCLES,
   parameter int WINDOW_CYCLES = tsbm_pkg::TSBM_WINDOW_CYCLES,
   parameter int INTERVAL_TICKS = tsbm_pkg::TSBM_INTERVAL_TICKS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // converter control bits held elsewhere
   input wire logic [2:0] conv_sel_i,
   input wire logic testbus_temp_i,
   input wire logic conv_start_i,
   output logic conv_busy_o,
   // analog sensor side
   input wire logic [7:0] byte_converter_i,
   output logic temp_sensor_on_o,
   output logic [1:0] temp_range_o,
   output logic abs_temp_mode_o,
   output logic trim_en_o,
   output logic [1:0] trim_code_o,
   output logic [1:0] vbg_trim_o,
   output logic [7:0] temp_value_o,
   // battery monitor
   input wire logic battery_monitor_en_i,
   input wire logic sleep_i,
   input wire logic lf_clk_i,
   input wire logic [4:0] battery_code_i,
   output logic battery_meas_on_o,
   output logic rc_osc_keep_o,
   // interrupt
   input wire logic battery_irq_en_i,
   input wire logic battery_irq_clr_i,
   output logic battery_irq_pend_o,
   output logic interrupt_out_low_o
);
   import tsbm_pkg::*;

   localparam int CW = $clog2(CONV_CYCLES + 1);
   localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
   localparam logic [1:0] LOW_LAST = 2'(TSBM_LOW_READINGS - 1);

   // ---------------------------------------------------------------
   // registers and state
   // ---------------------------------------------------------------
   logic [7:0] temp_ctrl_reg;
   logic [7:0] temp_offs_reg;
   logic [4:0] batt_thr_reg;
   logic [4:0] batt_level_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic conv_busy_reg;
   logic [CW-1:0] conv_cnt_reg;
   logic conv_end;
   logic sensor_on_reg;
   logic abs_mode_reg;
   logic [1:0] low_cnt_reg;
   logic irq_pend_reg;
   logic irq_low_n_reg;
   logic keep_osc_reg;
   logic lf_meta_reg;
   logic lf_sync_reg;
   logic lf_prev_reg;
   logic lf_tick;
   logic batt_low;
   logic low_event;

   tsbm_batt_if bif ();

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   // writable registers; threshold keeps its five valid bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         temp_ctrl_reg <= TSBM_RST_TEMP_CTRL;
         temp_offs_reg <= TSBM_RST_TEMP_OFFS;
         batt_thr_reg <= TSBM_RST_BATT_THR;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            TSBM_ADDR_TEMP_CTRL: begin
               temp_ctrl_reg <= reg_wdata_i;
            end
            TSBM_ADDR_TEMP_OFFS: begin
               temp_offs_reg <= reg_wdata_i;
            end
            TSBM_ADDR_BATT_THR: begin
               batt_thr_reg <= reg_wdata_i[TSBM_LEVEL_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // register reads
   // ---------------------------------------------------------------
   // read mux; unmapped offsets and reserved bits read zero
   always_comb begin
      rdata_next = 8'h00;
      case (reg_addr_i)
         TSBM_ADDR_TEMP_CTRL: begin
            rdata_next = temp_ctrl_reg;
         end
         TSBM_ADDR_TEMP_OFFS: begin
            rdata_next = temp_offs_reg;
         end
         TSBM_ADDR_BATT_THR: begin
            rdata_next = {3'h0, batt_thr_reg};
         end
         TSBM_ADDR_BATT_LEVEL: begin
            rdata_next = {3'h0, batt_level_reg};
         end
         default: begin
            rdata_next = 8'h00;
         end
      endcase
   end

   // read data registered one cycle after the address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ---------------------------------------------------------------
   // temperature sensor control
   // ---------------------------------------------------------------
   // sensor power and absolute mode decode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sensor_on_reg <= 1'b0;
         abs_mode_reg <= 1'b0;
      end else begin
         sensor_on_reg <= (conv_sel_i == TSBM_SEL_TEMP) || testbus_temp_i;
         abs_mode_reg <= !temp_ctrl_reg[TSBM_OFFS_EN_BIT]
            && (temp_ctrl_reg[TSBM_RANGE_HI:TSBM_RANGE_LO] == TSBM_RANGE_C_POS);
      end
   end

   // conversion timer: busy from start until the fixed time has passed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_busy_reg <= 1'b0;
         conv_cnt_reg <= '0;
      end else begin
         if (!conv_busy_reg) begin
            if (conv_start_i) begin
               conv_busy_reg <= 1'b1;
               conv_cnt_reg <= '0;
            end
         end else if (conv_end) begin
            conv_busy_reg <= 1'b0;
         end else begin
            conv_cnt_reg <= conv_cnt_reg + CW'(1);
         end
      end
   end

   // last busy cycle; the result loads on the same edge busy falls
   assign conv_end = conv_busy_reg && (conv_cnt_reg == CONV_LAST);

   // offset adder loads the raw code when the conversion ends
   tsbm_temp_offset #(
      .DATA_W(8)
   ) u_offset (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(conv_end),
      .offs_en_i(temp_ctrl_reg[TSBM_OFFS_EN_BIT]),
      .raw_i(byte_converter_i),
      .offs_i(temp_offs_reg),
      .value_o(temp_value_o)
   );

   // ---------------------------------------------------------------
   // low-frequency clock synchroniser and tick
   // ---------------------------------------------------------------
   // two flops, then a third for the rising edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lf_meta_reg <= 1'b0;
         lf_sync_reg <= 1'b0;
         lf_prev_reg <= 1'b0;
      end else begin
         lf_meta_reg <= lf_clk_i;
         lf_sync_reg <= lf_meta_reg;
         lf_prev_reg <= lf_sync_reg;
      end
   end

   assign lf_tick = lf_sync_reg && !lf_prev_reg;

   // ---------------------------------------------------------------
   // battery monitor
   // ---------------------------------------------------------------
   assign bif.enable = battery_monitor_en_i;
   assign bif.lf_tick = lf_tick;

   tsbm_batt_sampler #(
      .INTERVAL_TICKS(INTERVAL_TICKS),
      .WINDOW_CYCLES(WINDOW_CYCLES)
   ) u_sampler (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bif(bif)
   );

   // oscillator kept alive in sleep while the monitor is on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         keep_osc_reg <= 1'b0;
      end else begin
         keep_osc_reg <= battery_monitor_en_i && sleep_i;
      end
   end

   // latest five-bit code captured at the end of each window
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         batt_level_reg <= TSBM_RST_BATT_LEVEL;
      end else if (bif.sample_stb) begin
         batt_level_reg <= battery_code_i;
      end
   end

   assign batt_low = battery_code_i < batt_thr_reg;
   assign low_event = bif.sample_stb && batt_low && (low_cnt_reg == LOW_LAST);

   // run of consecutive low readings; a good reading restarts it
   always_ff @(posedge clk_i) begin
      if (rst_i || !battery_monitor_en_i) begin
         low_cnt_reg <= 2'h0;
      end else if (bif.sample_stb) begin
         if (!batt_low) begin
            low_cnt_reg <= 2'h0;
         end else if (low_cnt_reg == LOW_LAST) begin
            low_cnt_reg <= 2'h0;
         end else begin
            low_cnt_reg <= low_cnt_reg + 2'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt
   // ---------------------------------------------------------------
   // pending flag; a new event wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_pend_reg <= 1'b0;
      end else if (low_event) begin
         irq_pend_reg <= 1'b1;
      end else if (battery_irq_clr_i) begin
         irq_pend_reg <= 1'b0;
      end
   end

   // active-low pin gated by the enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_low_n_reg <= 1'b1;
      end else begin
         irq_low_n_reg <= !(irq_pend_reg && battery_irq_en_i);
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata_o = rdata_reg;
   assign conv_busy_o = conv_busy_reg;
   assign temp_sensor_on_o = sensor_on_reg;
   assign temp_range_o = temp_ctrl_reg[TSBM_RANGE_HI:TSBM_RANGE_LO];
   assign abs_temp_mode_o = abs_mode_reg;
   assign trim_en_o = temp_ctrl_reg[TSBM_TRIM_EN_BIT];
   assign trim_code_o = temp_ctrl_reg[TSBM_TRIM_HI:TSBM_TRIM_LO];
   assign vbg_trim_o = temp_ctrl_reg[TSBM_VBG_HI:TSBM_VBG_LO];
   assign battery_meas_on_o = bif.meas_on;
   assign rc_osc_keep_o = keep_osc_reg;
   assign battery_irq_pend_o = irq_pend_reg;
   assign interrupt_out_low_o = irq_low_n_reg;
endmodule
